// ### inc/cepm_pkg.sv
// Purpose: shared types and constants for the edge counter / period measure block
// Assumes: one 50 MHz clock, source, gate and aux pins asynchronous to it
// Notes:   modes are coded by the mode field of the cfg_i port
package cepm_pkg;

    localparam int unsigned CEPM_CNT_W  = 32;
    localparam logic [31:0] CEPM_CNT_RST = 32'h0000_0000;
    localparam logic [31:0] CEPM_CNT_ONE = 32'h0000_0001;

    // measurement modes
    typedef enum logic [2:0] {
        CEPM_MODE_EDGE      = 3'h0,
        CEPM_MODE_EDGE_BUF  = 3'h1,
        CEPM_MODE_EDGE_NCUM = 3'h2,
        CEPM_MODE_PW_SINGLE = 3'h3,
        CEPM_MODE_PW_BUF    = 3'h4,
        CEPM_MODE_PER_SGL   = 3'h5,
        CEPM_MODE_PER_BUF   = 3'h6,
        CEPM_MODE_SEMI_BUF  = 3'h7
    } cepm_mode_t;

    // count direction
    typedef enum logic [1:0] {
        CEPM_DIR_UP   = 2'h0,
        CEPM_DIR_DOWN = 2'h1,
        CEPM_DIR_PIN  = 2'h2
    } cepm_dir_t;

    // measurement state, gray along idle -> wait -> run -> done
    typedef enum logic [1:0] {
        CEPM_ST_IDLE = 2'b00,
        CEPM_ST_WAIT = 2'b01,
        CEPM_ST_RUN  = 2'b11,
        CEPM_ST_DONE = 2'b10
    } cepm_state_t;

    // configuration carrier
    typedef struct packed {
        cepm_mode_t mode;
        cepm_dir_t  dir;
        logic       src_fall;   // count falling source edges
        logic       gate_fall;  // gate active edge / low pulse / pause-low
        logic       pause_en;   // gate pauses counting in on-demand mode
    } cepm_cfg_t;

    // captured sample carrier
    typedef struct packed {
        logic                  valid;
        logic [CEPM_CNT_W-1:0] value;
    } cepm_sample_t;

endpackage

// ### hdl/cepm_core.sv
// Purpose: edge counting, pulse-width, period and semi-period measurement
// Assumes: source, gate and aux pins asynchronous; sampled by clk_i
// Notes:   buffered samples leave as a one-cycle strobe, no queue behind it
`timescale 1ns/1ps
module cepm_core
    import cepm_pkg::*;
#(
    parameter int unsigned CNT_W = CEPM_CNT_W
) (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     sys_rst_i,
    // external pins
    input  wire logic                     source_i,
    input  wire logic                     gate_i,
    input  wire logic                     aux_dir_i,
    // control
    input  wire cepm_pkg::cepm_cfg_t      cfg_i,
    input  wire logic                     arm_i,
    input  wire logic                     disarm_i,
    // status and data
    output logic [CNT_W-1:0]              count_o,
    output logic [CNT_W-1:0]              save_o,
    output logic                          save_valid_o,
    output cepm_pkg::cepm_sample_t        sample_o,
    output logic                          armed_o,
    output logic                          done_o
);
    import cepm_pkg::*;

    // two-stage synchronisers, only stage two is read
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [1:0] prev_reg;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            prev_reg  <= 2'h0;
        end else begin
            sync1_reg <= {aux_dir_i, gate_i, source_i};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg[1:0];
        end
    end

    wire src_s  = sync2_reg[0];
    wire gate_s = sync2_reg[1];
    wire aux_s  = sync2_reg[2];

    // edge pulses, one cycle each
    wire src_rise  = src_s & ~prev_reg[0];
    wire src_fallp = ~src_s & prev_reg[0];
    wire gate_rise = gate_s & ~prev_reg[1];
    wire gate_fl   = ~gate_s & prev_reg[1];

    wire src_edge  = cfg_i.src_fall ? src_fallp : src_rise;
    // gate_fall selects falling active edge / low pulse / low pause
    wire gate_lead  = cfg_i.gate_fall ? gate_fl : gate_rise;
    wire gate_trail = cfg_i.gate_fall ? gate_rise : gate_fl;
    wire gate_any   = gate_rise | gate_fl;
    wire gate_act   = gate_s ^ cfg_i.gate_fall;

    // mode decode
    wire m_edge  = cfg_i.mode == CEPM_MODE_EDGE;
    wire m_ebuf  = cfg_i.mode == CEPM_MODE_EDGE_BUF;
    wire m_encum = cfg_i.mode == CEPM_MODE_EDGE_NCUM;
    wire m_pws   = cfg_i.mode == CEPM_MODE_PW_SINGLE;
    wire m_pwb   = cfg_i.mode == CEPM_MODE_PW_BUF;
    wire m_pers  = cfg_i.mode == CEPM_MODE_PER_SGL;
    wire m_perb  = cfg_i.mode == CEPM_MODE_PER_BUF;
    wire m_semi  = cfg_i.mode == CEPM_MODE_SEMI_BUF;
    wire m_pw    = m_pws | m_pwb;
    wire m_edgec = m_edge | m_ebuf | m_encum;

    cepm_state_t state_reg;
    cepm_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] save_reg;
    logic             save_vld_reg;
    logic             smp_vld_reg;
    logic [CNT_W-1:0] smp_reg;

    wire running = state_reg == CEPM_ST_RUN;

    // pause only in on-demand edge counting
    wire paused = m_edge & cfg_i.pause_en & gate_act;

    // direction: edge modes only; measurements always count up
    wire dn = m_edgec & ((cfg_i.dir == CEPM_DIR_DOWN) |
              ((cfg_i.dir == CEPM_DIR_PIN) & ~aux_s));

    // capture event per mode while running
    wire cap_ebuf = (m_ebuf | m_encum) & gate_lead;
    wire cap_pw   = m_pw & gate_trail;
    wire cap_per  = (m_pers | m_perb) & gate_lead;
    wire cap_semi = m_semi & gate_any;
    wire capture  = running & (cap_ebuf | cap_pw | cap_per | cap_semi);

    // restart count after capture in interval modes
    wire clr_after = m_encum | m_pwb | m_perb | m_semi;
    wire single_stop = m_pws | m_pers;

    // count enable while running
    wire cnt_en = running & src_edge & ~paused & (~m_pw | gate_act);

    // source edge coinciding with capture lands in the next interval
    wire [CNT_W-1:0] cnt_step = dn ? (cnt_reg - CNT_W'(1)) : (cnt_reg + CNT_W'(1));
    wire [CNT_W-1:0] cnt_fresh = cnt_en ? CNT_W'(dn ? {CNT_W{1'b1}} : CNT_W'(1))
                                        : CNT_W'(0);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        if (disarm_i) begin
            state_next = CEPM_ST_IDLE;
        end else if (arm_i) begin
            cnt_next = CNT_W'(0);
            // pulse width waits for a fresh active start; single period
            // needs its first active edge; other modes run at once
            if (m_pw | m_pers)
                state_next = CEPM_ST_WAIT;
            else
                state_next = CEPM_ST_RUN;
        end else begin
            case (state_reg)
                CEPM_ST_WAIT: begin
                    if (m_pw ? gate_lead : (m_pers & gate_lead))
                        state_next = CEPM_ST_RUN;
                end
                CEPM_ST_RUN: begin
                    if (capture & single_stop) begin
                        state_next = CEPM_ST_DONE;
                    end else if (capture & clr_after) begin
                        cnt_next = cnt_fresh;
                    end else if (cnt_en) begin
                        cnt_next = cnt_step;
                    end
                end
                CEPM_ST_DONE: begin
                    state_next = CEPM_ST_DONE;
                end
                default: begin
                    state_next = CEPM_ST_IDLE;
                end
            endcase
        end
    end

    // pulse width in buffered mode stays running; the count restarts on each trailing edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= CEPM_ST_IDLE;
            cnt_reg   <= CNT_W'(CEPM_CNT_RST);
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // status from flops; next-state decode keeps them in step with state_reg
    wire armed_next = (state_next == CEPM_ST_RUN) | (state_next == CEPM_ST_WAIT);
    wire done_next  = state_next == CEPM_ST_DONE;
    logic armed_reg;
    logic done_reg;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            armed_reg <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            armed_reg <= armed_next;
            done_reg  <= done_next;
        end
    end

    // save register and stream strobe
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            save_reg     <= CNT_W'(CEPM_CNT_RST);
            save_vld_reg <= 1'b0;
            smp_reg      <= CNT_W'(CEPM_CNT_RST);
            smp_vld_reg  <= 1'b0;
        end else begin
            smp_vld_reg <= capture & ~disarm_i & ~arm_i & ~single_stop;
            if (arm_i | disarm_i)
                save_vld_reg <= 1'b0;
            if (capture & ~disarm_i & ~arm_i) begin
                save_reg     <= cnt_reg;
                save_vld_reg <= 1'b1;
                smp_reg      <= cnt_reg;
            end
        end
    end

    assign count_o         = cnt_reg;
    assign save_o          = save_reg;
    assign save_valid_o    = save_vld_reg;
    assign sample_o.valid  = smp_vld_reg;
    assign sample_o.value  = smp_reg;
    assign armed_o         = armed_reg;
    assign done_o          = done_reg;

    // checks
    AST_SYNC_DELAY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(src_s) |-> $past(source_i, 2))
        else $error("source sync bypassed");
    AST_DISARM_STOPS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        disarm_i |=> !armed_o && $stable(cnt_reg))
        else $error("disarm did not stop counter");
    AST_ARM_CLEARS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        arm_i && !disarm_i |=> cnt_reg == '0)
        else $error("arm did not clear count");
    AST_COUNT_UP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        running && cnt_en && !capture && !dn && !arm_i && !disarm_i
        |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
        else $error("count did not increment");
    AST_COUNT_DOWN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        running && cnt_en && !capture && dn && !arm_i && !disarm_i
        |=> cnt_reg == $past(cnt_reg) - CNT_W'(1))
        else $error("count did not decrement");
    AST_PAUSE_HOLDS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        paused && running && !arm_i && !disarm_i |=> $stable(cnt_reg))
        else $error("counted while paused");
    AST_CUM_KEEP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        capture && m_ebuf && !cnt_en && !arm_i && !disarm_i |=> $stable(cnt_reg))
        else $error("cumulative count cleared");
    AST_SAVE_VALUE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        capture && !arm_i && !disarm_i |=> save_o == $past(cnt_reg) && save_valid_o)
        else $error("save register mismatch");
    AST_SINGLE_DONE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        done_o && !arm_i && !disarm_i |=> done_o && $stable(cnt_reg) && $stable(save_o))
        else $error("single measure not frozen");
    AST_PW_GATE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        m_pw && !gate_act && !capture && !arm_i && !disarm_i |=> $stable(cnt_reg))
        else $error("pulse width counted outside pulse");

    // buffered modes
    AST_NCUM_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        capture && clr_after && !cnt_en && !arm_i && !disarm_i
        |=> cnt_reg == '0)
        else $error("interval count not cleared");
    AST_BUF_SAMPLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (m_ebuf || m_encum) && running && gate_lead && !arm_i && !disarm_i
        |=> sample_o.valid && sample_o.value == $past(cnt_reg))
        else $error("buffered edge sample missing");
    AST_RUN_AT_ARM: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        arm_i && !disarm_i && (m_ebuf || m_encum || m_perb || m_semi)
        |=> armed_o && running)
        else $error("buffered mode did not start at arm");
    AST_PW_TRAIL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        m_pwb && running && gate_trail && !arm_i && !disarm_i
        |=> sample_o.valid && cnt_reg == '0)
        else $error("trailing edge not latched");
    AST_PER_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        m_perb && capture && !cnt_en && !arm_i && !disarm_i
        |=> sample_o.valid && cnt_reg == '0)
        else $error("period not latched and restarted");
    AST_SEMI_EVERY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        m_semi && running && gate_any && !arm_i && !disarm_i
        |=> sample_o.valid && save_o == $past(cnt_reg))
        else $error("semi-period edge not latched");
    AST_MEAS_UP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        running && !m_edgec && cnt_en && !capture && !arm_i && !disarm_i
        |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
        else $error("measurement did not count up");

    // single modes
    AST_PW_WAITS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        arm_i && !disarm_i && m_pw
        |=> state_reg == CEPM_ST_WAIT && armed_o)
        else $error("pulse width did not wait for leading edge");
    AST_WAIT_IDLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_reg == CEPM_ST_WAIT && !arm_i && !disarm_i
        |=> $stable(cnt_reg) && !sample_o.valid)
        else $error("counted while waiting");
    AST_PER_FIRST: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_reg == CEPM_ST_WAIT && m_pers && gate_lead && !arm_i && !disarm_i
        |=> running && cnt_reg == '0)
        else $error("single period did not start on first edge");
    AST_SINGLE_STOPS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        capture && single_stop && !arm_i && !disarm_i
        |=> done_o && !armed_o)
        else $error("single measure did not stop");
    AST_SINGLE_QUIET: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (m_pws || m_pers) && !arm_i && !disarm_i
        |=> !sample_o.valid)
        else $error("single measure streamed a sample");

    // arm, disarm and idle
    AST_IDLE_FROZEN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        state_reg == CEPM_ST_IDLE && !arm_i
        |=> $stable(cnt_reg) && !sample_o.valid)
        else $error("idle counter moved");
    AST_NO_EDGE_STILL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !src_edge && !capture && !arm_i && !disarm_i
        |=> $stable(cnt_reg))
        else $error("count moved without source edge");
    AST_SAVE_HOLDS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !capture
        |=> $stable(save_o))
        else $error("save register moved without capture");
    AST_ARM_DROPS_VALID: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        arm_i || disarm_i
        |=> !save_valid_o && !done_o)
        else $error("arm or disarm left stale status");
    AST_DISARM_QUIET: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        disarm_i
        |=> !sample_o.valid && $stable(save_o))
        else $error("capture taken on disarm");

    COV_BUF_SAMPLE: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        m_ebuf && sample_o.valid);
    COV_PER_DONE: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        m_pers && $rose(done_o));
    COV_PW_DONE: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        m_pws && $rose(done_o));
    COV_SEMI: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        m_semi && sample_o.valid);
    COV_PW_BUF: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        m_pwb && sample_o.valid);

endmodule

// ### verif/cepm_pin_model.sv
// Purpose: far-side pins: source pulse train, gate level, direction pin
// Assumes: source runs at 160 ns per pulse, only inside bursts
// Notes:   tasks are called from the bench; each holds its level a while
`timescale 1ns/1ps
module cepm_pin_model (
    // pins toward the block
    output logic source_o,
    output logic gate_o,
    output logic aux_dir_o
);
    initial begin
        source_o = 1'b0;
        gate_o = 1'b0;
        aux_dir_o = 1'b1;
    end

    // source idles low between bursts, so no stray edge
    task automatic pulses(input int n);
        repeat (n) begin
            #80 source_o = 1'b1;
            #80 source_o = 0;
        end
    endtask

    // gate held 80 ns so the block sees every level
    task automatic set_gate(input logic v);
        gate_o = v;
        #80;
    endtask

    task automatic set_aux(input logic v);
        aux_dir_o = v;
        #80;
    endtask
endmodule

// ### verif/counter_edge_period_measure_tb.sv
// Purpose: self-checking bench for the edge counter / period measure block
// Assumes: 50 MHz clock, pins driven by the pin model
// Notes:   samples are queued as they stream out; no back-pressure exists
`timescale 1ns/1ps
module counter_edge_period_measure_tb;
    import cepm_pkg::*;
    logic         clk_i = 1'b0;
    logic         sys_rst_i = 1'b1;
    wire logic    src_w, gate_w, aux_w;
    cepm_cfg_t    cfg_i = '0;
    logic         arm_i = 1'b0;
    logic         disarm_i = 1'b0;
    logic         src_fall_sel = 1'b0;
    logic [31:0]  count_o, save_o;
    logic         save_valid_o, armed_o, done_o;
    cepm_sample_t sample_o;
    logic [31:0]  sq[$];
    int           fail_count = 0;
    int           num_checks = 0;
    int           cyc = 0;

    always #10 clk_i = ~clk_i;

    cepm_pin_model u_pin (.source_o(src_w), .gate_o(gate_w), .aux_dir_o(aux_w));

    cepm_core u_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .source_i(src_w), .gate_i(gate_w),
        .aux_dir_i(aux_w), .cfg_i(cfg_i), .arm_i(arm_i), .disarm_i(disarm_i),
        .count_o(count_o), .save_o(save_o), .save_valid_o(save_valid_o),
        .sample_o(sample_o), .armed_o(armed_o), .done_o(done_o)
    );

    // valid is a one-cycle strobe, so catch it every edge
    always @(posedge clk_i) begin
        if (sample_o.valid === 1'b1) begin
            sq.push_back(sample_o.value);
        end
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic start(input cepm_mode_t m, input cepm_dir_t d, input logic gf,
                         input logic pe);
        tick(1);
        cfg_i = '{mode: m, dir: d, src_fall: src_fall_sel, gate_fall: gf, pause_en: pe};
        sq.delete();
        arm_i = 1'b1;
        tick(1);
        arm_i = 1'b0;
        tick(2);
    endtask

    // pin changes need 2-3 cycles to land in the count
    task automatic settle(input string nm);
        tick(6);
        $display("test %s done", nm);
    endtask

    task automatic cs(input logic [31:0] exp);
        chk(sq.size() > 0 ? sq.pop_front() : 32'hxxxx_xxxx, exp);
    endtask

    task automatic buf_edge(input cepm_mode_t m, input logic [31:0] e2);
        // gate may be left high; drop it before arming so the first edge is real
        u_pin.set_gate(1'b0);
        start(m, CEPM_DIR_UP, 1'b0, 1'b0);
        u_pin.pulses(3);
        u_pin.set_gate(1'b1);
        u_pin.set_gate(1'b0);
        u_pin.pulses(2);
        u_pin.set_gate(1'b1);
        settle("buffered edge");
        cs(32'h0000_0003);
        cs(e2);
        chk(32'(sq.size()), 32'h0000_0000);
    endtask

    initial begin
        tick(2);
        sys_rst_i = 1'b0;
        start(CEPM_MODE_EDGE, CEPM_DIR_UP, 1'b0, 1'b0);
        u_pin.pulses(5);
        settle("count up");
        chk(count_o, 32'h0000_0005);
        start(CEPM_MODE_EDGE, CEPM_DIR_DOWN, 1'b0, 1'b0);
        u_pin.pulses(3);
        settle("count down");
        chk(count_o, 32'hFFFF_FFFD);
        start(CEPM_MODE_EDGE, CEPM_DIR_PIN, 1'b0, 1'b0);
        u_pin.pulses(4);
        u_pin.set_aux(1'b0);
        u_pin.pulses(1);
        settle("count by pin");
        chk(count_o, 32'h0000_0003);
        disarm_i = 1'b1;
        tick(1);
        disarm_i = 1'b0;
        u_pin.pulses(2);
        settle("disarm");
        chk(count_o, 32'h0000_0003);
        chk({31'h0, armed_o}, 32'h0000_0000);
        start(CEPM_MODE_EDGE, CEPM_DIR_UP, 1'b0, 1'b1);
        u_pin.set_gate(1'b1);
        u_pin.pulses(3);
        u_pin.set_gate(1'b0);
        u_pin.pulses(2);
        settle("pause");
        chk(count_o, 32'h0000_0002);
        src_fall_sel = 1'b1;
        start(CEPM_MODE_EDGE, CEPM_DIR_UP, 1'b0, 1'b0);
        u_pin.pulses(2);
        tick(4);
        chk(count_o, 32'h0000_0002);
        u_pin.pulses(1);
        settle("falling source");
        chk(count_o, 32'h0000_0003);
        src_fall_sel = 1'b0;
        start(CEPM_MODE_EDGE, CEPM_DIR_UP, 1'b1, 1'b1);
        u_pin.pulses(2);
        u_pin.set_gate(1'b1);
        u_pin.pulses(3);
        settle("pause low");
        chk(count_o, 32'h0000_0003);
        buf_edge(CEPM_MODE_EDGE_BUF, 32'h0000_0005);
        buf_edge(CEPM_MODE_EDGE_NCUM, 32'h0000_0002);
        // armed mid-pulse: the first pulse must be skipped
        start(CEPM_MODE_PW_SINGLE, CEPM_DIR_UP, 1'b0, 1'b0);
        u_pin.pulses(2);
        u_pin.set_gate(1'b0);
        u_pin.set_gate(1'b1);
        u_pin.pulses(3);
        u_pin.set_gate(1'b0);
        u_pin.pulses(2);
        u_pin.set_gate(1'b1);
        u_pin.set_gate(1'b0);
        settle("single pulse width");
        chk(save_o, 32'h0000_0003);
        chk({31'h0, done_o}, 32'h0000_0001);
        chk({31'h0, save_valid_o}, 32'h0000_0001);
        chk(32'(sq.size()), 32'h0000_0000);
        u_pin.set_gate(1'b1);
        start(CEPM_MODE_PW_BUF, CEPM_DIR_UP, 1'b1, 1'b0);
        u_pin.set_gate(1'b0);
        u_pin.pulses(2);
        u_pin.set_gate(1'b1);
        u_pin.pulses(1);
        u_pin.set_gate(1'b0);
        u_pin.pulses(4);
        u_pin.set_gate(1'b1);
        settle("buffered low pulse");
        cs(32'h0000_0002);
        cs(32'h0000_0004);
        u_pin.set_gate(1'b0);
        start(CEPM_MODE_PER_SGL, CEPM_DIR_UP, 1'b0, 1'b0);
        u_pin.pulses(1);
        u_pin.set_gate(1'b1);
        u_pin.pulses(3);
        u_pin.set_gate(1'b0);
        u_pin.pulses(1);
        u_pin.set_gate(1'b1);
        u_pin.pulses(2);
        u_pin.set_gate(1'b0);
        u_pin.set_gate(1'b1);
        settle("single period");
        chk(save_o, 32'h0000_0004);
        chk({31'h0, done_o}, 32'h0000_0001);
        chk(32'(sq.size()), 32'h0000_0000);
        start(CEPM_MODE_PER_BUF, CEPM_DIR_UP, 1'b0, 1'b0);
        u_pin.pulses(2);
        u_pin.set_gate(1'b0);
        u_pin.set_gate(1'b1);
        u_pin.pulses(1);
        u_pin.set_gate(1'b0);
        u_pin.pulses(2);
        u_pin.set_gate(1'b1);
        settle("buffered period");
        cs(32'h0000_0002);
        cs(32'h0000_0003);
        start(CEPM_MODE_SEMI_BUF, CEPM_DIR_UP, 1'b0, 1'b0);
        u_pin.pulses(1);
        u_pin.set_gate(1'b0);
        u_pin.pulses(2);
        u_pin.set_gate(1'b1);
        settle("buffered semi-period");
        cs(32'h0000_0001);
        cs(32'h0000_0002);
        complete_run();
    end
endmodule
